// ===== rtl/sram_init_bus_wrapper.sv
`timescale 1ns/1ps
`include "siw_cfg.svh"
module siw_sram_init_bus_wrapper
	import siw_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	// register port
	input  wire logic [`SIW_REG_AW-1:0] reg_addr_i,
	input  wire logic [31:0]            reg_wdata_i,
	input  wire logic                   reg_wr_i,
	input  wire logic                   reg_rd_i,
	output logic [31:0]                 reg_rdata_o,
	// external apb3 slave port
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [`SIW_ADDR_W-1:0] paddr_i,
	input  wire logic [`SIW_DATA_W-1:0] pwdata_i,
	output logic [`SIW_DATA_W-1:0]      prdata_o,
	output logic                        pready_o,
	// ahb-lite master toward the nonvolatile store
	output logic [31:0]                 haddr_o,
	output logic [1:0]                  htrans_o,
	output logic                        hwrite_o,
	output logic [2:0]                  hsize_o,
	output logic [31:0]                 hwdata_o,
	input  wire logic [31:0]            hrdata_i,
	input  wire logic                   hready_i,
	input  wire logic                   hresp_i,
	// user ram ports
	input  wire logic                   user_ren_i,
	input  wire logic [`SIW_ADDR_W-1:0] user_raddr_i,
	output logic [`SIW_DATA_W-1:0]      user_rdata_o,
	input  wire logic                   user_wen_i,
	input  wire logic [`SIW_ADDR_W-1:0] user_waddr_i,
	input  wire logic [`SIW_DATA_W-1:0] user_wdata_i,
	// status
	output logic                        init_complete_o,
	output logic                        user_port_select_o,
	output logic                        ram_loaded_flag_o,
	output logic                        ahb_busy_o,
	output logic [1:0]                  master_error_response_o
);
	siw_state_t st;         // registered state
	siw_state_t next_st;    // next state
	siw_apb_t   int_apb;    // request from the fabric master
	siw_apb_t   bus;        // request seen by the wrapper
	siw_ram_t   ram;        // ports into the memory
	logic [`SIW_DATA_W-1:0] ram_rdata; // registered read data
	logic       wr_hit;     // decoded ram write
	logic       rd_hit;     // decoded ram read
	logic       bus_pready; // wrapper ready
	logic [7:0] store_byte; // selected byte lane of hrdata

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////
	// register bank decode, used by write and read paths
	function automatic logic is_reg(input logic [`SIW_REG_AW-1:0] a, input logic [`SIW_REG_AW-1:0] o);
		is_reg = (a == o);
	endfunction

	////////////////////////////////////////////////////////////////
	// internal apb request from the fabric master
	always_comb begin
		int_apb        = '0;
		int_apb.addr   = st.idx;
		int_apb.wdata  = st.byte_q;
		int_apb.write  = 1'b1;
		// setup for one clock, then access with fields unchanged
		int_apb.sel    = (st.fm == FM_SETUP) || (st.fm == FM_ACCESS);
		int_apb.enable = (st.fm == FM_ACCESS);
	end

	// wrapper listens to the fabric master or the outside port
	assign bus = st.mode ? int_apb : siw_apb_t'{sel: psel_i, enable: penable_i, write: pwrite_i,
		addr: paddr_i, wdata: pwdata_i};

	////////////////////////////////////////////////////////////////
	// apb3 wrapper decode, only while loading
	assign wr_hit = bus.sel && bus.enable && bus.write && !st.sel_user;
	assign rd_hit = bus.sel && bus.enable && !bus.write && !st.sel_user;
	// reads wait one cycle for the clocked ram output
	assign bus_pready = rd_hit ? st.rd_wait : 1'b1;

	// outside port answer; while fabric master owns the bus it sees ready and zeros
	assign pready_o = st.mode ? 1'b1 : bus_pready;
	// after the switch a bus read returns zeros
	assign prdata_o = (!st.mode && rd_hit) ? ram_rdata : '0;

	////////////////////////////////////////////////////////////////
	// port mux: wrapper while loading, user after the switch
	always_comb begin
		if (st.sel_user) begin
			// user owns both ports
			ram.ren   = user_ren_i;
			ram.raddr = user_raddr_i;
			ram.we    = user_wen_i;
			ram.waddr = user_waddr_i;
			ram.wdata = user_wdata_i;
		end else begin
			// first port serves bus reads, second bus writes
			ram.ren   = rd_hit;
			ram.raddr = bus.addr;
			ram.we    = wr_hit;
			ram.waddr = bus.addr;
			ram.wdata = bus.wdata;
		end
	end

	// 64 x 8 two-port memory
	siw_ram64x8 u_ram (
		.ref_clk_i (ref_clk_i),
		.port_i    (ram),
		.rdata_o   (ram_rdata)
	);

	// user sees data only once it owns the ram
	assign user_rdata_o = st.sel_user ? ram_rdata : '0;

	////////////////////////////////////////////////////////////////
	// ahb-lite master drive, read-only byte fetches
	assign htrans_o = (st.fm == FM_ADDR) ? `SIW_HTRANS_NSEQ : `SIW_HTRANS_IDLE;
	assign haddr_o  = `SIW_STORE_BASE + {26'h0, st.idx};
	assign hwrite_o = 1'b0;
	assign hsize_o  = `SIW_HSIZE_BYTE;
	assign hwdata_o = '0; // constant, so stable in any extended phase
	assign store_byte = hrdata_i[{haddr_o[1:0], 3'h0} +: 8];

	////////////////////////////////////////////////////////////////
	// status outputs
	assign init_complete_o         = st.sel_user;
	assign user_port_select_o      = st.sel_user;
	assign ram_loaded_flag_o       = st.sel_user;
	assign ahb_busy_o              = (st.fm != FM_IDLE) && (st.fm != FM_DONE);
	assign master_error_response_o = st.resp;
	assign reg_rdata_o             = st.reg_rdata;

	////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st = st;
		// read data stand for one cycle only
		next_st.reg_rdata = '0;
		if (reg_rd_i) begin
			if (is_reg(reg_addr_i, `SIW_REG_CTRL)) begin
				next_st.reg_rdata[`SIW_CTRL_MODE] = st.mode;
			end else if (is_reg(reg_addr_i, `SIW_REG_STATUS)) begin
				next_st.reg_rdata[`SIW_ST_DONE]                  = st.sel_user;
				next_st.reg_rdata[`SIW_ST_SEL]                   = st.sel_user;
				next_st.reg_rdata[`SIW_ST_BUSY]                  = ahb_busy_o;
				next_st.reg_rdata[`SIW_ST_RESP_LO+:2]            = st.resp;
				next_st.reg_rdata[`SIW_ST_MODE]                  = st.mode;
				next_st.reg_rdata[`SIW_ST_IDX_LO+:`SIW_ADDR_W]   = st.idx;
			end
		end
		// mode may change only while the fabric master is idle, before the switch
		if (reg_wr_i && is_reg(reg_addr_i, `SIW_REG_CTRL) && (st.fm == FM_IDLE) && !st.sel_user) begin
			next_st.mode = reg_wdata_i[`SIW_CTRL_MODE];
		end

		// read wait flag: first access cycle low ready, second high
		next_st.rd_wait = rd_hit && !st.rd_wait;

		// switch right after the last address is written, then sticky
		if (wr_hit && (bus.addr == `SIW_LAST_ADDR)) begin
			next_st.sel_user = 1'b1;
		end

		// fabric master sequence
		case (st.fm)
			FM_IDLE: begin
				if (next_st.mode && !st.sel_user) begin // a mode write on this edge keeps it parked
					next_st.fm = FM_ADDR;
				end
			end
			FM_ADDR: begin
				// address phase stands until hready accepts it
				if (hready_i) begin
					next_st.fm = FM_DATA;
				end
			end
			FM_DATA: begin
				// capture only on the ready cycle of the data phase
				if (hready_i) begin
					next_st.byte_q = store_byte;
					next_st.resp   = {1'b0, hresp_i};
					next_st.fm     = FM_SETUP;
				end
			end
			FM_SETUP: begin
				next_st.fm = FM_ACCESS;
			end
			FM_ACCESS: begin
				// held while ready is low, then next word or done
				if (bus_pready) begin
					if (st.idx == `SIW_LAST_ADDR) begin
						next_st.fm = FM_DONE;
					end else begin
						next_st.idx = st.idx + 6'h01;
						next_st.fm  = FM_ADDR;
					end
				end
			end
			FM_DONE: begin
				next_st.fm = FM_DONE;
			end
			default: begin
				next_st.fm = FM_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register; reset restarts from address zero
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st          <= '0;
			st.fm       <= FM_IDLE;
			st.mode     <= `SIW_CTRL_MODE_RST;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks on the wrapper decode
	wr_decode_a: assert property ((!st.sel_user && ram.we) |-> (bus.sel && bus.enable && bus.write))
		else $error("ram write without selected enabled write");
	rd_wait_a: assert property ((rd_hit && !st.rd_wait) |-> (!bus_pready ##1 (bus_pready && rd_hit)))
		else $error("read did not take exactly one wait state");
	rd_port_a: assert property ((!st.sel_user && ram.ren) |-> (!ram.we && !bus.write))
		else $error("read port used for a write");

	// checks on the port switch
	switch_a: assert property ((wr_hit && bus.addr == `SIW_LAST_ADDR) |=> (user_port_select_o && init_complete_o))
		else $error("port select not raised after last write");
	sel_sticky_a: assert property ($rose(user_port_select_o) |=> user_port_select_o [*4])
		else $error("port select dropped");
	readback_zero_a: assert property ((st.sel_user && !st.mode && psel_i && penable_i && !pwrite_i) |-> (prdata_o == 8'h00))
		else $error("bus read after switch not zero");
	user_mux_a: assert property (st.sel_user |-> (ram.we == user_wen_i && ram.ren == user_ren_i))
		else $error("user enables not routed to ram");
	loaded_flag_a: assert property (ram_loaded_flag_o == init_complete_o)
		else $error("loaded flag differs from init complete");

	// checks on the fabric master
	store_addr_a: assert property ((htrans_o == `SIW_HTRANS_NSEQ) |-> (haddr_o[31:6] == `SIW_STORE_BASE >> 6))
		else $error("fetch outside the image region");
	addr_hold_a: assert property ((st.fm == FM_ADDR && !hready_i) |=> (st.fm == FM_ADDR && $stable(haddr_o)))
		else $error("address phase not held while not ready");
	data_hold_a: assert property ((st.fm == FM_DATA && !hready_i) |=> (st.fm == FM_DATA && $stable(st.byte_q)))
		else $error("data captured while not ready");
	access_hold_a: assert property ((st.fm == FM_ACCESS && !bus_pready) |=> (st.fm == FM_ACCESS && $stable(int_apb)))
		else $error("access phase left while not ready");
	one_setup_a: assert property ((st.fm == FM_SETUP) |=> (st.fm == FM_ACCESS && int_apb.addr == $past(int_apb.addr)))
		else $error("setup phase longer than one clock");
	busy_a: assert property ((st.fm == FM_DATA) |-> ahb_busy_o)
		else $error("busy low during transfer");

	// main scenarios
	load_done_c: cover property ($rose(init_complete_o));
	read_wait_c: cover property (rd_hit && !bus_pready ##1 rd_hit && bus_pready);
	ahb_wait_c:  cover property (st.fm == FM_DATA && !hready_i ##1 hready_i);
	error_c:     cover property (st.fm == FM_DATA && hready_i && hresp_i);
endmodule

// ===== rtl/siw_cfg.svh
// How it works
// - memory is 64 words of 8 bits
// - image fetched from page 16, address 0x800
// - slave ready low holds the access phase
// - ram enables decoded from select, enable, direction
// - ready adds one wait state on reads
// - bus wrapper owns both ram ports while loading
// - first port reads, second writes, both clocked
// - port select hands both ports to user
// - port select also driven out for debug
// - switch right after last address is written
// - init complete low until the last address (0x3f) is written
// - after completion user inputs reach the ram
// - fabric master copies every store word into ram
// - fabric master holds address while bus not ready
// - read data captured only with bus ready
`ifndef SIW_CFG_SVH
`define SIW_CFG_SVH

// memory geometry
`define SIW_DATA_W       8
`define SIW_ADDR_W       6
`define SIW_LAST_ADDR    6'h3f
// nonvolatile image location
`define SIW_STORE_PAGE   16
`define SIW_STORE_BASE   32'h0000_0800
// ahb-lite encodings
`define SIW_HTRANS_IDLE  2'h0
`define SIW_HTRANS_NSEQ  2'h2
`define SIW_HSIZE_BYTE   3'h0
// register port map
`define SIW_REG_AW       4
`define SIW_REG_CTRL     4'h0
`define SIW_REG_STATUS   4'h4
// control fields and reset value
`define SIW_CTRL_MODE    0
`define SIW_CTRL_MODE_RST 1'h1
// status fields
`define SIW_ST_DONE      0
`define SIW_ST_SEL       1
`define SIW_ST_BUSY      2
`define SIW_ST_RESP_LO   3
`define SIW_ST_MODE      5
`define SIW_ST_IDX_LO    8

`endif

// ===== rtl/siw_pkg.sv
`include "siw_cfg.svh"
package siw_pkg;
	// fabric master sequence
	typedef enum logic [2:0] {
		FM_IDLE,
		FM_ADDR,
		FM_DATA,
		FM_SETUP,
		FM_ACCESS,
		FM_DONE
	} siw_fm_state_t;

	// one apb request toward the wrapper
	typedef struct packed {
		logic                   sel;
		logic                   enable;
		logic                   write;
		logic [`SIW_ADDR_W-1:0] addr;
		logic [`SIW_DATA_W-1:0] wdata;
	} siw_apb_t;

	// ram port pair: read port then write port
	typedef struct packed {
		logic                   ren;
		logic [`SIW_ADDR_W-1:0] raddr;
		logic                   we;
		logic [`SIW_ADDR_W-1:0] waddr;
		logic [`SIW_DATA_W-1:0] wdata;
	} siw_ram_t;

	// whole state of the loader
	typedef struct packed {
		siw_fm_state_t          fm;
		logic [`SIW_ADDR_W-1:0] idx;
		logic [`SIW_DATA_W-1:0] byte_q;
		logic [1:0]             resp;
		logic                   rd_wait;
		logic                   sel_user;
		logic                   mode;
		logic [31:0]            reg_rdata;
	} siw_state_t;
endpackage

// ===== rtl/siw_ram64x8.sv
`timescale 1ns/1ps
`include "siw_cfg.svh"
module siw_ram64x8
	import siw_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire siw_ram_t               port_i,
	output logic [`SIW_DATA_W-1:0]      rdata_o
);
	// storage array, no reset on contents
	logic [`SIW_DATA_W-1:0] mem [0:(1<<`SIW_ADDR_W)-1];

	////////////////////////////////////////////////////////////////
	// second port: clocked write
	always_ff @(posedge ref_clk_i) begin
		if (port_i.we) begin
			mem[port_i.waddr] <= port_i.wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// first port: clocked read, data held from a register
	always_ff @(posedge ref_clk_i) begin
		if (port_i.ren) begin
			rdata_o <= mem[port_i.raddr];
		end
	end
endmodule

// ===== dv/siw_store_model.sv
`timescale 1ns/1ps
`include "siw_cfg.svh"
module siw_store_model (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic [7:0]  image_i [64],
	input  wire logic [5:0]  err_idx_i,
	input  wire logic [2:0]  max_wait_i,
	output logic [31:0]      hrdata_o,
	output logic             hready_o,
	output logic             hresp_o
);
	logic        open;	// data phase running
	logic [3:0]  cnt;	// wait cycles left
	logic [31:0] addr;	// address of the running phase
	logic [31:0] last;	// word last handed out
	logic        err;	// phase ends in error

	////////////////////////////////////////////////////////////////
	// ready low while waits remain; error is a two-cycle answer
	always_comb begin
		hready_o = !open || cnt == 4'h0;
		hresp_o  = open && err && cnt <= 4'h1;
		// idle bus shows the inverse of the last word, not a copy
		hrdata_o = ~last;
		if (open && cnt == 4'h0) begin
			hrdata_o[8*addr[1:0] +: 8] = image_i[addr[5:0]];
		end
	end

	////////////////////////////////////////////////////////////////
	// take an address only with ready high, draw a random wait count
	always @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			open <= 1'b0;
			cnt  <= 4'h0;
			err  <= 1'b0;
			addr <= 32'h0;
			last <= 32'h0;
		end else if (hready_o) begin
			if (open) begin
				last <= hrdata_o;
			end
			open <= htrans_i == `SIW_HTRANS_NSEQ;
			addr <= haddr_i;
			err  <= haddr_i[5:0] == err_idx_i;
			cnt  <= 4'($urandom_range(max_wait_i)) + 4'(haddr_i[5:0] == err_idx_i);
		end else begin
			cnt <= cnt - 4'h1;
		end
	end
endmodule

// ===== dv/siw_sram_init_bus_wrapper_test.sv
`timescale 1ns/1ps
`include "siw_cfg.svh"
module siw_sram_init_bus_wrapper_test
	import siw_pkg::*;
;
	logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic psel_i = 0, penable_i = 0, pwrite_i = 0, hready_i, hresp_i;
	logic user_ren_i = 0, user_wen_i = 0, pready_o, init_complete_o, user_port_select_o;
	logic ram_loaded_flag_o, ahb_busy_o, hwrite_o;
	logic [2:0] hsize_o;	// fetch size, byte expected
	logic [31:0] hwdata_o;	// unused write data, zero expected
	logic [3:0] reg_addr_i = 0;
	logic [31:0] reg_wdata_i = 0, reg_rdata_o, haddr_o, hrdata_i;
	logic [5:0] paddr_i = 0, user_raddr_i = 0, user_waddr_i = 0, err_idx = 6'h0a;
	logic [7:0] pwdata_i = 0, user_wdata_i = 0, prdata_o, user_rdata_o;
	logic [1:0] htrans_o, master_error_response_o;
	logic [2:0] max_wait = 3'h3;	// store stall depth
	logic [7:0] image [64];	// store content
	logic reg_rd_d = 0, user_rd_d = 0;	// read answers due
	int ld_cnt = 0, bad_count = 0, comparisons = 0, cycles = 0;
	typedef struct {string what; logic [31:0] exp; logic [31:0] mask;} siw_note_t;
	siw_note_t notes[$];	// expected answers, oldest first

	siw_sram_init_bus_wrapper siw_sram_init_bus_wrapper_i (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .haddr_o, .htrans_o, .hwrite_o, .hsize_o, .hwdata_o, .hrdata_i, .hready_i, .hresp_i,
		.user_ren_i, .user_raddr_i, .user_rdata_o, .user_wen_i, .user_waddr_i, .user_wdata_i, .init_complete_o,
		.user_port_select_o, .ram_loaded_flag_o, .ahb_busy_o, .master_error_response_o);
	siw_store_model siw_store_model_i (.ref_clk_i, .rst_n_i, .haddr_i(haddr_o), .htrans_i(htrans_o),
		.image_i(image), .err_idx_i(err_idx), .max_wait_i(max_wait), .hrdata_o(hrdata_i), .hready_o(hready_i),
		.hresp_o(hresp_i));

	always #20 ref_clk_i = ~ref_clk_i;

	////////////////////////////////////////////////////////////////
	// compare, count, report
	function automatic void check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endfunction
	task automatic final_report();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic do_reset(int n);
		rst_n_i <= 1'b0;
		tick(n);
		rst_n_i <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	// watcher: pops the oldest note when an answer is due
	always @(posedge ref_clk_i) begin
		siw_note_t n;
		if (reg_rd_d || user_rd_d || (psel_i && penable_i && pready_o && !pwrite_i)) begin
			n = notes.pop_front();
			check(n.what, n.exp, (reg_rd_d ? reg_rdata_o : 32'(psel_i ? prdata_o : user_rdata_o)) & n.mask);
		end
		if (!rst_n_i) ld_cnt <= 0;
		else if (htrans_o === `SIW_HTRANS_NSEQ && hready_i) begin
			check("store address", `SIW_STORE_BASE + ld_cnt, haddr_o);
			check("fetch kind", 32'h0, 32'({hwrite_o, hsize_o}) | hwdata_o);
			ld_cnt <= ld_cnt + 1;
		end
		reg_rd_d <= reg_rd_i;
		user_rd_d <= user_ren_i;
	end

	////////////////////////////////////////////////////////////////
	// timeout: a hang counts as a mismatch and ends the run
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////
	// bus tasks: register/user reads, user writes, apb transfers
	task automatic rd(bit user, logic [5:0] a, logic [31:0] exp, logic [31:0] mask);
		notes.push_back('{user ? "user read" : "status", exp, mask});
		@(posedge ref_clk_i);
		if (user) user_raddr_i <= a;
		else reg_addr_i <= a[3:0];
		if (user) user_ren_i <= 1'b1;
		else reg_rd_i <= 1'b1;
		tick();
		user_ren_i <= 1'b0;
		reg_rd_i <= 1'b0;
		tick(2);
	endtask
	task automatic uwr(logic [5:0] a, logic [7:0] d);
		@(posedge ref_clk_i);
		user_waddr_i <= a;
		user_wdata_i <= d;
		user_wen_i <= 1'b1;
		tick();
		user_wen_i <= 1'b0;
		user_wdata_i <= ~d;
	endtask
	task automatic apb(logic w, logic [5:0] a, logic [7:0] d, int exp_wait);
		int waits;
		waits = 0;
		if (!w) notes.push_back('{"apb read", 32'(d), 32'hff});
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		tick();
		penable_i <= 1'b1;
		tick();
		while (pready_o !== 1'b1 && waits < 8) begin
			waits++;
			tick();
		end
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		paddr_i <= ~a;
		pwdata_i <= ~d;
		check("apb wait states", 32'(exp_wait), 32'(waits));
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] d;
		void'($urandom(43464));
		foreach (image[i]) image[i] = 8'($urandom);
		// reset in mid-load restarts from the first word
		do_reset(20);
		// stop in the address phase of word 11, just after the erroring word 10
		while (!(htrans_o === `SIW_HTRANS_NSEQ && haddr_o[5:0] === 6'h0b)) @(negedge ref_clk_i);
		check("error response", 32'h1, 32'(master_error_response_o));
		check("busy", 32'h1, 32'(ahb_busy_o));
		check("complete early", 32'h0, 32'(init_complete_o));
		tick();
		do_reset(3);
		@(negedge ref_clk_i);
		check("select in reset", 32'h0, 32'({init_complete_o, user_port_select_o}));
		$display("test reset_mid_load done");
		// full fabric load, then user access
		while (init_complete_o !== 1'b1) tick();
		@(negedge ref_clk_i);
		check("words fetched", 32'd64, 32'(ld_cnt));
		check("flags", 32'h6, 32'({user_port_select_o, ram_loaded_flag_o, ahb_busy_o}));
		rd(0, 6'h4, 32'h23, 32'h3f);
		for (int i = 0; i < 64; i++) rd(1, 6'(i), 32'(image[i]), 32'hff);
		for (int i = 0; i < 8; i++) begin
			d = 8'($urandom);
			uwr(6'(i * 9), d);
			rd(1, 6'(i * 9), 32'(d), 32'hff);
		end
		apb(1, 6'h05, 8'h5a, 0);
		rd(1, 6'h05, 32'(image[5]), 32'hff);
		apb(0, 6'h3f, 8'h00, 0);
		$display("test fabric_load done");
		// processor-driven load through the apb port
		do_reset(3);
		// mode write on the first edge after release keeps the fabric master parked
		reg_addr_i <= `SIW_REG_CTRL;
		reg_wdata_i <= {31'($urandom), 1'b0};
		reg_wr_i <= 1'b1;
		tick();
		reg_wr_i <= 1'b0;
		rd(0, 6'h4, 32'h0, 32'h27);
		for (int i = 0; i < 64; i++) begin
			image[i] = 8'($urandom);
			apb(1, 6'(i), image[i], 0);
			// the last write switches the ports, so its read-back is zero with no wait
			if (i % 9 == 0) apb(0, 6'(i), (i == 63) ? 8'h00 : image[i], (i == 63) ? 0 : 1);
			@(negedge ref_clk_i);
			check("complete", 32'(i == 63), 32'(init_complete_o));
		end
		apb(0, 6'h3f, 8'h00, 0);
		rd(1, 6'h3f, 32'(image[63]), 32'hff);
		check("no store fetch", 32'h0, 32'(ld_cnt));
		$display("test apb_load done");
		final_report();
	end
endmodule
